// >>> tb/brownout_chk.sv
// Port checker of the brown-out monitor
`timescale 1ns/100ps
module brownout_chk #(
	parameter int SAMPLE_CYCLES = 8
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire brownout_pkg::wb_req_t wb_req_i,
	input wire logic [7:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] boot_option_byte_two_i,
	input wire logic boot_option_byte_two_programmed_i,
	input wire logic below_threshold_i,
	input wire brownout_pkg::analog_ctrl_t analog_ctrl_o,
	input wire logic brownout_irq_o,
	input wire logic [1:0] brownout_prio_o,
	input wire logic brownout_reset_o
);
	int gap_r;
	logic seen_r;
	logic [1:0] thr;
	assign thr = boot_option_byte_two_programmed_i ? boot_option_byte_two_i[6:5] : 2'h3;
	// Cycles since the last sample tick, valid while sampling stays on
	always_ff @(posedge clk_i)
	begin
		gap_r <= analog_ctrl_o.sample_strobe ? 0 : gap_r + 1;
		seen_r <= !rst_i && analog_ctrl_o.slow_osc_enable
			&& (seen_r || analog_ctrl_o.sample_strobe);
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_once_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
		else $error("read data outside ack");
	rst_quiet_a: assert property ($fell(rst_i) |-> !brownout_irq_o
		&& !brownout_reset_o && brownout_prio_o == 2'h0 && !wb_ack_o)
		else $error("outputs not clear after reset");
	rst_pulse_a: assert property (brownout_reset_o |=> !brownout_reset_o)
		else $error("reset request longer than one cycle");
	no_cause_a: assert property (!below_threshold_i [*4] |=>
		!brownout_reset_o) else $error("reset without brown-out");
	hyst_off_a: assert property (analog_ctrl_o.slow_osc_enable |->
		!analog_ctrl_o.hysteresis_enable) else $error("hysteresis in sampling");
	lp_gate_a: assert property (analog_ctrl_o.slow_osc_enable |->
		analog_ctrl_o.analog_enable) else $error("sampling without detection");
	sample_gap_a: assert property (analog_ctrl_o.sample_strobe && seen_r
		|-> gap_r == SAMPLE_CYCLES - 1) else $error("sample period wrong");
	thr_sel_a: assert property (analog_ctrl_o.analog_enable |->
		analog_ctrl_o.threshold_sel == thr) else $error("threshold select wrong");
	cover property (brownout_reset_o);
	cover property (brownout_irq_o);
	cover property (analog_ctrl_o.sample_strobe && seen_r);
endmodule : brownout_chk

// >>> tb/brownout_monitor_tb.sv
// Self-checking bench of the brown-out monitor
`timescale 1ns/100ps
`define CHK(g, e) check_val(g, e)
module brownout_monitor_tb;
	localparam int SAMPLE_CYCLES = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	brownout_pkg::wb_req_t req = '0;
	logic [7:0] rdat;
	logic [7:0] cfg = 8'h00;
	logic cfg_prog = 1'b0;
	logic supply_low = 1'b0;
	logic below;
	brownout_pkg::analog_ctrl_t actl;
	logic [7:0] wb_dat;
	logic ack;
	logic irq;
	logic [1:0] prio;
	logic bor;
	int miscompares = 0;
	int total_checks = 0;
	int resets = 0;
	always #10 clk_i = !clk_i;
	always @(posedge clk_i)
		if (bor === 1'b1)
			resets <= resets + 1;
	task automatic check_val(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check_val
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		logic got;
		n = 0;
		req <= '{adr: a, dat: d, we: we, sel: 1'b1, cyc: 1'b1, stb: 1'b1};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		got = (ack === 1'b1);
		rdat = wb_dat;
		req <= '0;
		@(posedge clk_i);
		if (!got)
		begin
			miscompares++;
			stop_test();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 8'h00);
	endtask : rd
	// Unlock with the two keys, then the protected control write
	task automatic unlock_wr(input logic [7:0] d);
		bus(1'b1, brownout_pkg::ADDR_TIMED_ACCESS, 8'hAA);
		bus(1'b1, brownout_pkg::ADDR_TIMED_ACCESS, 8'h55);
		bus(1'b1, brownout_pkg::ADDR_PMC, d);
	endtask : unlock_wr
	task automatic pmc_is(input logic [7:0] e);
		repeat (6) @(posedge clk_i);
		rd(brownout_pkg::ADDR_PMC);
		`CHK(rdat, e);
	endtask : pmc_is
	task automatic do_reset(input logic [7:0] c);
		cfg <= c;
		cfg_prog <= 1'b1;
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : do_reset
	task automatic t_defaults();
		pmc_is(8'h90);
		rd(brownout_pkg::ADDR_BOOT_OPTION_BYTE_TWO);
		`CHK(rdat, 8'hFF);
		rd(brownout_pkg::ADDR_PRIO_HIGH);
		`CHK(rdat, 8'h00);
		rd(brownout_pkg::ADDR_PRIO_LOW);
		`CHK(rdat, 8'h00);
		rd(8'h10);
		`CHK(rdat, 8'h00);
		bus(1'b1, brownout_pkg::ADDR_PMC, 8'h00);
		pmc_is(8'h90);
		unlock_wr(8'h10);
		pmc_is(8'h10);
		unlock_wr(8'h98);
		pmc_is(8'h90);
		$display("defaults and protection done");
	endtask : t_defaults
	task automatic t_event();
		bus(1'b1, brownout_pkg::ADDR_IRQ_EN, 8'h84);
		supply_low <= 1'b1;
		pmc_is(8'h99);
		`CHK(8'(resets), 8'h01);
		`CHK(8'(irq), 8'h01);
		unlock_wr(8'h90);
		pmc_is(8'h91);
		`CHK(8'(irq), 8'h00);
		supply_low <= 1'b0;
		pmc_is(8'h98);
		`CHK(8'(resets), 8'h01);
		bus(1'b1, brownout_pkg::ADDR_IRQ_EN, 8'h04);
		`CHK(8'(irq), 8'h00);
		bus(1'b1, brownout_pkg::ADDR_PRIO_HIGH, 8'hFF);
		bus(1'b1, brownout_pkg::ADDR_PRIO_LOW, 8'h02);
		`CHK(8'(prio), 8'h02);
		rd(brownout_pkg::ADDR_PRIO_HIGH);
		`CHK(rdat, 8'h07);
		bus(1'b1, brownout_pkg::ADDR_PRIO_LOW, 8'h04);
		`CHK(8'(prio), 8'h03);
		$display("event, irq and priority done");
	endtask : t_event
	task automatic t_config();
		do_reset(8'hAF);
		pmc_is(8'h80);
		rd(brownout_pkg::ADDR_BOOT_OPTION_BYTE_TWO);
		`CHK(rdat, 8'hAF);
		supply_low <= 1'b1;
		pmc_is(8'h89);
		`CHK(8'(resets), 8'h01);
		supply_low <= 1'b0;
		do_reset(8'h7F);
		supply_low <= 1'b1;
		pmc_is(8'h10);
		unlock_wr(8'h14);
		`CHK(8'(actl.slow_osc_enable), 8'h00);
		unlock_wr(8'h84);
		`CHK(8'(actl.slow_osc_enable), 8'h01);
		repeat (2 * SAMPLE_CYCLES) @(posedge clk_i);
		pmc_is(8'h8D);
		$display("configuration and sampling done");
	endtask : t_config
	supply_comparator_model u_supply_comparator_model (.clk_i(clk_i),
		.ctrl_i(actl), .supply_low_i(supply_low), .below_o(below));
	brownout_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_brownout_monitor (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat),
		.wb_ack_o(ack), .boot_option_byte_two_i(cfg), .boot_option_byte_two_programmed_i(cfg_prog),
		.below_threshold_i(below), .analog_ctrl_o(actl),
		.brownout_irq_o(irq), .brownout_prio_o(prio), .brownout_reset_o(bor));
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_defaults();
		t_event();
		t_config();
		stop_test();
	end
endmodule : brownout_monitor_tb
bind brownout_monitor brownout_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .boot_option_byte_two_i(boot_option_byte_two_i),
	.boot_option_byte_two_programmed_i(boot_option_byte_two_programmed_i),
	.below_threshold_i(below_threshold_i), .analog_ctrl_o(analog_ctrl_o),
	.brownout_irq_o(brownout_irq_o), .brownout_prio_o(brownout_prio_o),
	.brownout_reset_o(brownout_reset_o));

// >>> tb/supply_comparator_model.sv
// Behavioural supply comparator facing the brown-out monitor
`timescale 1ns/100ps
module supply_comparator_model
(
	input wire logic clk_i,
	input wire brownout_pkg::analog_ctrl_t ctrl_i,
	input wire logic supply_low_i,
	output logic below_o
);
	logic junk_r = 1'b0;
	// A powered-down comparator gives no valid answer
	always @(posedge clk_i)
		junk_r <= !junk_r;
	assign below_o = ctrl_i.analog_enable ? supply_low_i : junk_r;
endmodule : supply_comparator_model

// >>> verilog/brownout_monitor.sv
// Brown-out monitor control: registers, detection, flag, irq and reset
`timescale 1ns/100ps
module brownout_monitor #(
	parameter int SAMPLE_CYCLES = brownout_pkg::SAMPLE_PERIOD_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire brownout_pkg::wb_req_t wb_req_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] boot_option_byte_two_i,
	input wire logic boot_option_byte_two_programmed_i,
	input wire logic below_threshold_i,
	output brownout_pkg::analog_ctrl_t analog_ctrl_o,
	output logic brownout_irq_o,
	output logic [1:0] brownout_prio_o,
	output logic brownout_reset_o
);

	logic [7:0] config_byte;
	logic brownout_detect_enable_r;
	logic brownout_reset_enable_r;
	logic brownout_flag_r;
	logic low_power_sampling_enable_r;
	logic brownout_level_now_r;
	logic level_prev_r;
	logic [7:0] prio_high_r;
	logic [7:0] prio_low_r;
	logic [7:0] irq_en_r;
	brownout_pkg::ta_state_t ta_state_r;
	logic [1:0] ta_count_r;
	logic [31:0] sample_count_r;
	logic sample_tick;
	logic sample_now;
	logic comparator_ready;
	logic crossing;
	logic bus_access;
	logic bus_write;
	logic ta_open;
	logic pmc_write;
	logic [7:0] pmc_read;
	logic [7:0] rd_nxt;
	logic [7:0] wr_dat;

	// ------------------------------------------------------------
	// Configuration byte and bus decode
	// ------------------------------------------------------------
	assign config_byte = boot_option_byte_two_programmed_i ? boot_option_byte_two_i
		: brownout_pkg::BOOT_OPTION_BYTE_TWO_UNPROGRAMMED;
	assign bus_access = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	assign bus_write = bus_access && wb_req_i.we && wb_req_i.sel;
	assign wr_dat = wb_req_i.dat;
	assign ta_open = (ta_state_r == brownout_pkg::TA_OPEN);
	assign pmc_write = bus_write && ta_open
		&& (wb_req_i.adr == brownout_pkg::ADDR_PMC);

	// ------------------------------------------------------------
	// Timed-access unlock
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ta_state_r <= brownout_pkg::TA_IDLE;
			ta_count_r <= 2'h0;
		end
		else if (bus_write
			&& wb_req_i.adr == brownout_pkg::ADDR_TIMED_ACCESS)
		begin
			ta_count_r <= 2'h0;
			if (wr_dat == brownout_pkg::KEY_FIRST)
				ta_state_r <= brownout_pkg::TA_ARMED;
			else if (wr_dat == brownout_pkg::KEY_SECOND
				&& ta_state_r == brownout_pkg::TA_ARMED)
				ta_state_r <= brownout_pkg::TA_OPEN;
			else
				ta_state_r <= brownout_pkg::TA_IDLE;
		end
		else
		begin
			unique case (ta_state_r)
				brownout_pkg::TA_IDLE:
					ta_count_r <= 2'h0;
				brownout_pkg::TA_ARMED,
				brownout_pkg::TA_OPEN:
				begin
					if (ta_count_r == 2'(brownout_pkg::TA_WINDOW_CYCLES - 1))
					begin
						ta_state_r <= brownout_pkg::TA_IDLE;
						ta_count_r <= 2'h0;
					end
					else
						ta_count_r <= ta_count_r + 2'h1;
				end
				default:
				begin
					ta_state_r <= brownout_pkg::TA_IDLE;
					ta_count_r <= 2'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Low-power sampling timer
	// ------------------------------------------------------------
	assign sample_tick = (sample_count_r == 32'(SAMPLE_CYCLES - 1));
	assign sample_now = low_power_sampling_enable_r ? sample_tick
		: 1'b1;
	// Comparator answers only after its enable has gone out
	assign comparator_ready = analog_ctrl_o.analog_enable;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !brownout_detect_enable_r
			|| !low_power_sampling_enable_r || sample_tick)
			sample_count_r <= 32'h0;
		else
			sample_count_r <= sample_count_r + 32'h1;
	end

	// ------------------------------------------------------------
	// Comparator level and crossing detect
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			brownout_level_now_r <= 1'b0;
		else if (!brownout_detect_enable_r)
			brownout_level_now_r <= 1'b0;
		else if (sample_now && comparator_ready)
			brownout_level_now_r <= below_threshold_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			level_prev_r <= 1'b0;
		else
			level_prev_r <= brownout_level_now_r;
	end

	assign crossing = brownout_detect_enable_r
		&& (level_prev_r != brownout_level_now_r);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brownout_detect_enable_r <=
				config_byte[brownout_pkg::CFG_DETECT_EN];
			brownout_reset_enable_r <=
				config_byte[brownout_pkg::CFG_RESET_EN];
			low_power_sampling_enable_r <= 1'b0;
		end
		else if (pmc_write)
		begin
			brownout_detect_enable_r <= wr_dat[brownout_pkg::PMC_DETECT_EN];
			brownout_reset_enable_r <= wr_dat[brownout_pkg::PMC_RESET_EN];
			low_power_sampling_enable_r <=
				wr_dat[brownout_pkg::PMC_LOW_POWER];
		end
	end

	// ------------------------------------------------------------
	// Brown-out flag
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			brownout_flag_r <= 1'b0;
		else if (crossing)
			brownout_flag_r <= 1'b1;
		else if (pmc_write && !wr_dat[brownout_pkg::PMC_FLAG])
			brownout_flag_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Priority and enable registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prio_high_r <= brownout_pkg::PRIO_RESET;
		else if (bus_write
			&& wb_req_i.adr == brownout_pkg::ADDR_PRIO_HIGH)
			prio_high_r <= wr_dat & brownout_pkg::PRIO_MASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prio_low_r <= brownout_pkg::PRIO_RESET;
		else if (bus_write
			&& wb_req_i.adr == brownout_pkg::ADDR_PRIO_LOW)
			prio_low_r <= wr_dat & brownout_pkg::PRIO_MASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_en_r <= brownout_pkg::IRQ_EN_RESET;
		else if (bus_write
			&& wb_req_i.adr == brownout_pkg::ADDR_IRQ_EN)
			irq_en_r <= wr_dat;
	end

	// ------------------------------------------------------------
	// Bus read data select
	// ------------------------------------------------------------
	always_comb
	begin
		pmc_read = 8'h00;
		pmc_read[brownout_pkg::PMC_DETECT_EN] = brownout_detect_enable_r;
		pmc_read[brownout_pkg::PMC_RESET_EN] = brownout_reset_enable_r;
		pmc_read[brownout_pkg::PMC_FLAG] = brownout_flag_r;
		pmc_read[brownout_pkg::PMC_LOW_POWER] = low_power_sampling_enable_r;
		pmc_read[brownout_pkg::PMC_LEVEL_NOW] = brownout_level_now_r;
		unique case (wb_req_i.adr)
			brownout_pkg::ADDR_PMC: rd_nxt = pmc_read;
			brownout_pkg::ADDR_PRIO_HIGH: rd_nxt = prio_high_r;
			brownout_pkg::ADDR_PRIO_LOW: rd_nxt = prio_low_r;
			brownout_pkg::ADDR_BOOT_OPTION_BYTE_TWO: rd_nxt = config_byte;
			brownout_pkg::ADDR_IRQ_EN: rd_nxt = irq_en_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Bus acknowledge and read data
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_access;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 8'h00;
		else
			wb_dat_o <= bus_access ? rd_nxt : 8'h00;
	end

	// ------------------------------------------------------------
	// Analog control outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			analog_ctrl_o <= '0;
		else
		begin
			analog_ctrl_o.analog_enable <= brownout_detect_enable_r;
			analog_ctrl_o.slow_osc_enable <= brownout_detect_enable_r
				&& low_power_sampling_enable_r;
			analog_ctrl_o.hysteresis_enable <=
				!low_power_sampling_enable_r;
			analog_ctrl_o.sample_strobe <= brownout_detect_enable_r
				&& sample_now;
			analog_ctrl_o.threshold_sel <= {
				config_byte[brownout_pkg::CFG_THR_HI],
				config_byte[brownout_pkg::CFG_THR_LO]};
		end
	end

	// ------------------------------------------------------------
	// Interrupt, priority and reset outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			brownout_irq_o <= 1'b0;
		else
			brownout_irq_o <= brownout_flag_r
				&& irq_en_r[brownout_pkg::IRQ_EN_BROWNOUT]
				&& irq_en_r[brownout_pkg::IRQ_EN_GLOBAL];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			brownout_prio_o <= 2'h0;
		else
			brownout_prio_o <= {prio_high_r[brownout_pkg::PRIO_BROWNOUT],
				prio_low_r[brownout_pkg::PRIO_BROWNOUT]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			brownout_reset_o <= 1'b0;
		else
			brownout_reset_o <= crossing && brownout_level_now_r
				&& brownout_reset_enable_r;
	end

endmodule : brownout_monitor

// >>> verilog/brownout_pkg.sv
// Constants, register map and carrier types of the brown-out monitor
// Function
// - Detection runs only while the run-time detect-enable bit is 1.
// - Reset-enable bit 1 makes a brown-out event request a system reset.
// - Flag is set by hardware on a threshold crossing in either direction.
// - Interrupt request while flag set, local and global enables both 1.
// - Flag never clears itself; software writes 0 to clear it.
// - Low-power sampling bit has no effect unless detection is enabled; the code still drives hysteresis_enable from it.
// - Low-power bit 0 with detection on monitors the supply continuously.
// - Low-power bit 1 runs the slow oscillator, sampling every 12.8 ms.
// - Sampled mode detects discretely, with comparator hysteresis disabled.
// - Control register writes land only in an open timed-access window.
// - Configuration detect-enable bit 1 enables detection, 0 disables it.
// - Threshold select 11=2.2V, 10=2.7V, 01=3.8V, 00=4.5V.
// - Configuration reset-enable bit 1 enables brown-out reset, 0 disables.
// - Unprogrammed configuration byte reads all ones.
// - Interrupt priority is the high bit joined with the low bit.
// - Both extended priority registers reset to zero.
package brownout_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the bus)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PMC = 8'hAC;
	localparam logic [7:0] ADDR_PRIO_HIGH = 8'hBB;
	localparam logic [7:0] ADDR_PRIO_LOW = 8'hBC;
	localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hC7;
	localparam logic [7:0] ADDR_BOOT_OPTION_BYTE_TWO = 8'hE0;
	localparam logic [7:0] ADDR_IRQ_EN = 8'hE8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PMC_DETECT_EN = 7;
	localparam int PMC_RESET_EN = 4;
	localparam int PMC_FLAG = 3;
	localparam int PMC_LOW_POWER = 2;
	localparam int PMC_LEVEL_NOW = 0;
	localparam int CFG_DETECT_EN = 7;
	localparam int CFG_THR_HI = 6;
	localparam int CFG_THR_LO = 5;
	localparam int CFG_RESET_EN = 4;
	localparam int PRIO_BROWNOUT = 2;
	localparam int IRQ_EN_BROWNOUT = 2;
	localparam int IRQ_EN_GLOBAL = 7;

	// ------------------------------------------------------------
	// Reset values and keys
	// ------------------------------------------------------------
	localparam logic [7:0] BOOT_OPTION_BYTE_TWO_UNPROGRAMMED = 8'hFF;
	localparam logic [7:0] PRIO_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] KEY_FIRST = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	localparam logic [7:0] PMC_WRITE_MASK = 8'h9C;
	localparam logic [7:0] PRIO_MASK = 8'h07;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int TA_WINDOW_CYCLES = 3;
	localparam int SAMPLE_PERIOD_US = 12800;
	localparam int SLOW_OSC_HZ = 10000;
	localparam int SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1000000);

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] dat;
		logic we;
		logic sel;
		logic cyc;
		logic stb;
	} wb_req_t;

	typedef struct packed {
		logic analog_enable;
		logic slow_osc_enable;
		logic hysteresis_enable;
		logic sample_strobe;
		logic [1:0] threshold_sel;
	} analog_ctrl_t;

	typedef enum logic [1:0] {
		TA_IDLE,
		TA_ARMED,
		TA_OPEN
	} ta_state_t;

endpackage : brownout_pkg
